// File: hdl/clock_select_params.svh
`ifndef CLOCK_SELECT_PARAMS_SVH
`define CLOCK_SELECT_PARAMS_SVH

// Register byte offsets
`define OFS_SYSTEM_CONFIG     4'h0
`define OFS_PLL_CONFIG        4'h4
`define OFS_OUTPUT_DIVIDER    4'h8
`define OFS_CLOCK_STATUS      4'hc

// Field positions in pll_config_reg
`define POS_VCO_BYPASS        0
`define POS_OSC_INTERNAL      1
`define POS_PLL_INPUT_DIV     4
`define POS_PLL_MULT          8
`define POS_PLL_OUTPUT_DIV    16

// Field widths
`define W_SOURCE_SELECT       2
`define W_OUTPUT_DIVIDER      10
`define W_PLL_INPUT_DIV       4
`define W_PLL_MULT            8
`define W_PLL_OUTPUT_DIV      7
`define W_PERIOD              16

// Reset values
`define RST_SOURCE_SELECT     2'h0
`define RST_VCO_BYPASS        1'h1
`define RST_OUTPUT_DIVIDER    10'h000

// Largest prescaler divide factor
`define MAX_PRESCALER_FACTOR  11'h400

`endif

// File: hdl/clock_select_pkg.sv
package clock_select_pkg;

    typedef enum logic [1:0] {
        SRC_WAKEUP    = 2'h0,
        SRC_UNUSED    = 2'h1,
        SRC_PLL_PRESC = 2'h2,
        SRC_DIRECT    = 2'h3
    } clock_source_t;

    typedef struct packed {
        logic [6:0] pll_output_divider_setting;
        logic [7:0] pll_multiplier_setting;
        logic [3:0] pll_input_divider_setting;
        logic       osc_internal;
        logic       vco_bypass;
    } pll_config_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [3:0]  adr;
        logic [31:0] dat;
    } wb_request_t;

endpackage : clock_select_pkg

// File: hdl/system_clock_source_select.sv
// Contract
// - Select code 11 drives the system clock straight from the direct clock input.
// - Select code 10 with vco_bypass set takes the system clock through the prescaler from crystal or internal source.
// - The prescaler divides by output_divider_setting plus one.
// - With a factor of one the system clock copies the source clock including its duty cycle.
// - The largest setting divides by 1024, the slowest prescaler output.
// - Bypass from the crystal input with factor one behaves like direct drive.
// - Select code 10 with vco_bypass clear runs the PLL and uses its output.
// - The PLL ratio is N over P times K2, each field value plus one.
// - Select code 00 runs the system clock from the wakeup clock.
`timescale 1ns/1ns
`include "clock_select_params.svh"

module system_clock_source_select (
    // Clock and reset
    input  wire logic                         clock,
    input  wire logic                         reset_n,
    // Wishbone slave
    input  wire clock_select_pkg::wb_request_t wb_req,
    output logic                              wb_ack_o,
    output logic [31:0]                       wb_dat_o,
    // Clock sources, sampled on clock
    input  wire logic                         direct_clock_input,
    input  wire logic                         crystal_input,
    input  wire logic                         internal_clock_input,
    input  wire logic                         wakeup_clock_input,
    // Generated clock
    output logic                              sys_clock_q
);
    import clock_select_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register file

    clock_source_t                    source_q;
    pll_config_t                      pll_cfg_q;
    logic [`W_OUTPUT_DIVIDER-1:0]     div_set_q;
    logic                             ack_q;
    logic [31:0]                      rdata_q;

    function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge_bytes

    wire         bus_req   = wb_req.cyc && wb_req.stb && !ack_q;
    wire         bus_wr    = bus_req && wb_req.we;
    wire         hit_sys   = wb_req.adr == `OFS_SYSTEM_CONFIG;
    wire         hit_pll   = wb_req.adr == `OFS_PLL_CONFIG;
    wire         hit_div   = wb_req.adr == `OFS_OUTPUT_DIVIDER;
    wire         hit_stat  = wb_req.adr == `OFS_CLOCK_STATUS;
    wire [31:0]  sys_word  = {30'h0, source_q};
    wire [31:0]  pll_word  = {9'h0, pll_cfg_q.pll_output_divider_setting,
                              pll_cfg_q.pll_multiplier_setting,
                              pll_cfg_q.pll_input_divider_setting,
                              2'h0, pll_cfg_q.osc_internal, pll_cfg_q.vco_bypass};
    wire [31:0]  div_word  = {22'h0, div_set_q};
    wire [31:0]  sys_new   = merge_bytes(sys_word, wb_req.dat, wb_req.sel);
    wire [31:0]  pll_new   = merge_bytes(pll_word, wb_req.dat, wb_req.sel);
    wire [31:0]  div_new   = merge_bytes(div_word, wb_req.dat, wb_req.sel);
    logic        pll_run;
    logic        presc_run;
    wire [31:0]  stat_word = {28'h0, pll_run, presc_run, 1'b0, sys_clock_q};
    // Unmapped offsets read as zero and are still acknowledged
    wire [31:0]  read_mux  = hit_sys  ? sys_word :
                             hit_pll  ? pll_word :
                             hit_div  ? div_word :
                             hit_stat ? stat_word : 32'h0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h0;
        end else begin
            ack_q   <= bus_req;
            rdata_q <= bus_req ? read_mux : 32'h0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            source_q  <= clock_source_t'(`RST_SOURCE_SELECT);
            pll_cfg_q <= '{vco_bypass: `RST_VCO_BYPASS, default: '0};
            div_set_q <= `RST_OUTPUT_DIVIDER;
        end else if (bus_wr) begin
            if (hit_sys) begin
                source_q <= clock_source_t'(sys_new[1:0]);
            end
            if (hit_pll) begin
                pll_cfg_q <= {pll_new[`POS_PLL_OUTPUT_DIV +: `W_PLL_OUTPUT_DIV],
                              pll_new[`POS_PLL_MULT +: `W_PLL_MULT],
                              pll_new[`POS_PLL_INPUT_DIV +: `W_PLL_INPUT_DIV],
                              pll_new[`POS_OSC_INTERNAL], pll_new[`POS_VCO_BYPASS]};
            end
            if (hit_div) begin
                div_set_q <= div_new[`W_OUTPUT_DIVIDER-1:0];
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Oscillator selection and edge detection

    logic osc_prev_q;
    wire  osc_level = pll_cfg_q.osc_internal ? internal_clock_input : crystal_input;
    wire  osc_rise  = osc_level && !osc_prev_q;

    assign presc_run = (source_q == SRC_PLL_PRESC) && pll_cfg_q.vco_bypass;
    assign pll_run   = (source_q == SRC_PLL_PRESC) && !pll_cfg_q.vco_bypass;

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler: counts source rising edges, factor is setting plus one

    logic [`W_OUTPUT_DIVIDER-1:0] edge_cnt_q;
    logic                         presc_q;
    wire  [10:0]                  presc_factor = {1'b0, div_set_q} + 11'h1;
    wire  [`W_OUTPUT_DIVIDER-1:0] half_cnt  = presc_factor[10:1];
    wire                          cnt_wrap  = edge_cnt_q >= div_set_q;
    wire  [`W_OUTPUT_DIVIDER-1:0] cnt_next  = cnt_wrap ? '0 : edge_cnt_q + 1'b1;
    // Factor one copies the source so its duty cycle survives
    wire                          presc_lvl = (div_set_q == '0) ? osc_level : presc_q;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            osc_prev_q <= 1'b0;
            edge_cnt_q <= '0;
            presc_q    <= 1'b0;
        end else begin
            osc_prev_q <= osc_level;
            if (!presc_run) begin
                edge_cnt_q <= '0;
                presc_q    <= 1'b0;
            end else if (osc_rise) begin
                edge_cnt_q <= cnt_next;
                presc_q    <= cnt_next < half_cnt;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // PLL model: measures the input period, then a phase accumulator
    // synthesises period * P * K2 / N. Output is limited by the 100 MHz
    // sampling: at most half the clock, with one cycle of jitter.

    logic [`W_PERIOD-1:0] per_cnt_q;
    logic [`W_PERIOD-1:0] period_q;
    logic [27:0]          acc_q;
    logic                 pll_q;
    logic                 seen_q;
    wire  [4:0]           p_fac    = {1'b0, pll_cfg_q.pll_input_divider_setting} + 5'h1;
    wire  [8:0]           n_fac    = {1'b0, pll_cfg_q.pll_multiplier_setting} + 9'h1;
    wire  [7:0]           k2_fac   = {1'b0, pll_cfg_q.pll_output_divider_setting} + 8'h1;
    wire  [27:0]          pll_lim  = 28'(period_q * p_fac * k2_fac);
    wire  [27:0]          acc_sum  = acc_q + {18'h0, n_fac, 1'b0};
    wire                  acc_wrap = acc_sum >= pll_lim;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            per_cnt_q <= '0;
            period_q  <= '0;
            acc_q     <= '0;
            pll_q     <= 1'b0;
            seen_q    <= 1'b0;
        end else if (!pll_run) begin
            per_cnt_q <= '0;
            period_q  <= '0;
            acc_q     <= '0;
            pll_q     <= 1'b0;
            seen_q    <= 1'b0;
        end else begin
            per_cnt_q <= osc_rise ? '0 : per_cnt_q + 1'b1;
            if (osc_rise) begin
                seen_q <= 1'b1;
            end
            // First rise only opens the window; a partial count would skew the ratio
            if (osc_rise && seen_q) begin
                period_q <= per_cnt_q + 1'b1;
            end
            // Hold until one full input period has been measured
            if (period_q != '0) begin
                acc_q <= acc_wrap ? acc_sum - pll_lim : acc_sum;
                pll_q <= acc_wrap ? !pll_q : pll_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Output selection; code 01 is reserved and holds the clock low

    wire sys_next = (source_q == SRC_DIRECT) ? direct_clock_input :
                    (source_q == SRC_WAKEUP) ? wakeup_clock_input :
                    presc_run                ? presc_lvl :
                    pll_run                  ? pll_q : 1'b0;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sys_clock_q <= 1'b0;
        end else begin
            sys_clock_q <= sys_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_direct_follow: assert property (@(posedge clock) disable iff (!reset_n)
        (reset_n && source_q == SRC_DIRECT) |=> sys_clock_q == $past(direct_clock_input))
        else $error("system clock does not follow direct input");

    a_wakeup_follow: assert property (@(posedge clock) disable iff (!reset_n)
        (reset_n && source_q == SRC_WAKEUP) |=> sys_clock_q == $past(wakeup_clock_input))
        else $error("system clock does not follow wakeup input");

    a_factor_one_copy: assert property (@(posedge clock) disable iff (!reset_n)
        (reset_n && presc_run && div_set_q == '0) |=> sys_clock_q == $past(osc_level))
        else $error("factor one does not copy the oscillator");

    a_crystal_bypass: assert property (@(posedge clock) disable iff (!reset_n)
        (reset_n && presc_run && div_set_q == '0 && !pll_cfg_q.osc_internal)
            |=> sys_clock_q == $past(crystal_input))
        else $error("crystal bypass does not behave like direct drive");

    a_presc_count: assert property (@(posedge clock) disable iff (!reset_n)
        (presc_run && osc_rise && edge_cnt_q == div_set_q && $stable(div_set_q))
            |=> edge_cnt_q == '0)
        else $error("prescaler count does not wrap at the setting");

    a_presc_max: assert property (@(posedge clock) disable iff (!reset_n)
        (div_set_q == 10'h3ff) |-> presc_factor == `MAX_PRESCALER_FACTOR)
        else $error("largest setting is not a divide by 1024");

    a_presc_full_range: assert property (@(posedge clock) disable iff (!reset_n)
        (presc_run && osc_rise && div_set_q == 10'h3ff && edge_cnt_q == 10'h3fe
            && $stable(div_set_q)) |=> edge_cnt_q == 10'h3ff)
        else $error("largest setting wraps before 1024 source edges");

    a_presc_source: assert property (@(posedge clock) disable iff (!reset_n)
        (reset_n && presc_run && div_set_q != '0) |=> sys_clock_q == $past(presc_q))
        else $error("prescaler output not selected");

    a_pll_idle: assert property (@(posedge clock) disable iff (!reset_n)
        !pll_run |=> (!pll_q && acc_q == '0))
        else $error("pll runs while not selected");

    a_pll_bound: assert property (@(posedge clock) disable iff (!reset_n)
        (pll_run && $stable(pll_cfg_q) && $stable(period_q) && period_q != '0 && acc_q < pll_lim)
            |=> acc_q < pll_lim || acc_q < {18'h0, n_fac, 1'b0})
        else $error("pll accumulator passes its limit");

    a_ack_pulse: assert property (@(posedge clock) disable iff (!reset_n)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

endmodule : system_clock_source_select

// File: dv/clock_source_model.sv
`timescale 1ns/1ns
module clock_source_model #(
    parameter int DIR_PER = 10,
    parameter int DIR_HI  = 3,
    parameter int XTL_PER = 16,
    parameter int XTL_HI  = 6,
    parameter int INT_PER = 4,
    parameter int INT_HI  = 2,
    parameter int WAK_PER = 12,
    parameter int WAK_HI  = 6
) (
    // Bench clock
    input  wire logic clock,
    // Source levels
    output logic      direct_clock_input,
    output logic      crystal_input,
    output logic      internal_clock_input,
    output logic      wakeup_clock_input
);
    int tick_q = 0;

    always_ff @(posedge clock) begin
        tick_q <= tick_q + 1;
    end

    // Uneven duty on direct and crystal on purpose, so a copied duty cycle is visible
    assign direct_clock_input   = (tick_q % DIR_PER) < DIR_HI;
    assign crystal_input        = (tick_q % XTL_PER) < XTL_HI;
    assign internal_clock_input = (tick_q % INT_PER) < INT_HI;
    assign wakeup_clock_input   = (tick_q % WAK_PER) < WAK_HI;
endmodule : clock_source_model

// File: dv/system_clock_source_select_bench.sv
`timescale 1ns/1ns
module system_clock_source_select_bench;
    import clock_select_pkg::*;

    logic                   clock;
    logic                   reset_n;
    wb_request_t            wb_req;
    logic                   wb_ack_o;
    logic [31:0]            wb_dat_o;
    logic                   dir_in, xtl_in, int_in, wak_in;
    logic                   sys_clock_q;
    int                     failures = 0;
    int                     tests_run = 0;
    logic [31:0]            rd;

    system_clock_source_select dut (.clock(clock), .reset_n(reset_n), .wb_req(wb_req),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .direct_clock_input(dir_in),
        .crystal_input(xtl_in), .internal_clock_input(int_in),
        .wakeup_clock_input(wak_in), .sys_clock_q(sys_clock_q));

    clock_source_model src (.clock(clock), .direct_clock_input(dir_in),
        .crystal_input(xtl_in), .internal_clock_input(int_in),
        .wakeup_clock_input(wak_in));

    ////////////////////////////////////////////////////////////////////////////////
    task end_sim;
        $display("Counts: %0d compared, %0d mismatched", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : end_sim

    task check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task wb_cycle(input logic we, input logic [3:0] adr, input logic [31:0] dat);
        int n;
        @(posedge clock);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: dat};
        for (n = 0; n < 20; n++) begin
            @(posedge clock);
            if (wb_ack_o === 1'b1) break;
        end
        rd = wb_dat_o;
        wb_req <= '0;
        if (n == 20) begin
            failures++;
            end_sim();
        end
    endtask : wb_cycle

    // Measures one full output period in clock samples, from rise to rise
    task measure(output int hi, output int per);
        int  n;
        logic p;
        hi = 1;
        per = 1;
        p = sys_clock_q;
        for (n = 0; n < 20000; n++) begin
            @(posedge clock);
            if (p === 1'b0 && sys_clock_q === 1'b1) break;
            p = sys_clock_q;
        end
        p = 1'b1;
        for (n = n; n < 20000; n++) begin
            @(posedge clock);
            if (p === 1'b0 && sys_clock_q === 1'b1) break;
            per++;
            if (sys_clock_q === 1'b1) hi++;
            p = sys_clock_q;
        end
        if (n >= 20000) begin
            failures++;
            end_sim();
        end
    endtask : measure

    // Skips the settling periods, then judges the last one
    task expect_clk(input int per, input int hi);
        int h, p;
        repeat (3) measure(h, p);
        check(32'(p), 32'(per));
        if (hi >= 0) check(32'(h), 32'(hi));
    endtask : expect_clk

    ////////////////////////////////////////////////////////////////////////////////
    task t_regs;
        wb_cycle(1'b0, 4'h0, 32'h0); check(rd, 32'h0);
        wb_cycle(1'b0, 4'h4, 32'h0); check(rd, 32'h1);
        wb_cycle(1'b0, 4'h8, 32'h0); check(rd, 32'h0);
        wb_cycle(1'b1, 4'h8, 32'hffff_ffff);
        wb_cycle(1'b0, 4'h8, 32'h0); check(rd, 32'h3ff);
        wb_cycle(1'b1, 4'h2, 32'hffff_ffff);
        wb_cycle(1'b0, 4'h2, 32'h0); check(rd, 32'h0);
        wb_cycle(1'b1, 4'h8, 32'h0);
        $display("Test registers done");
    endtask : t_regs

    task t_sources;
        expect_clk(12, 6);
        wb_cycle(1'b1, 4'h0, 32'h3);
        expect_clk(10, 3);
        // Reserved select code must hold the clock low
        wb_cycle(1'b1, 4'h0, 32'h1);
        repeat (16) begin
            @(posedge clock);
            check(32'(sys_clock_q), 32'h0);
        end
        wb_cycle(1'b1, 4'h0, 32'h2);
        expect_clk(16, 6);
        wb_cycle(1'b1, 4'h4, 32'h3);
        expect_clk(4, 2);
        wb_cycle(1'b0, 4'hc, 32'h0);
        check(rd & 32'hffff_fffe, 32'h4);
        $display("Test sources done");
    endtask : t_sources

    task t_divide;
        wb_cycle(1'b1, 4'h4, 32'h1);
        wb_cycle(1'b1, 4'h8, 32'h2);
        expect_clk(48, 16);
        wb_cycle(1'b1, 4'h8, 32'h5);
        expect_clk(96, 48);
        wb_cycle(1'b1, 4'h4, 32'h3);
        wb_cycle(1'b1, 4'h8, 32'h3ff);
        expect_clk(4096, 2048);
        $display("Test divide done");
    endtask : t_divide

    task t_pll;
        wb_cycle(1'b1, 4'h8, 32'h0);
        wb_cycle(1'b1, 4'h4, 32'h0000_0100);
        expect_clk(8, -1);
        wb_cycle(1'b0, 4'hc, 32'h0);
        check(rd & 32'hffff_fffe, 32'h8);
        $display("Test pll done");
    endtask : t_pll

    // Reset in mid-run, with the pll running
    task t_reset;
        @(posedge clock);
        reset_n <= 1'b0;
        repeat (3) @(posedge clock);
        check({30'h0, wb_ack_o, sys_clock_q}, 32'h0);
        check(wb_dat_o, 32'h0);
        reset_n <= 1'b1;
        wb_cycle(1'b0, 4'h0, 32'h0); check(rd, 32'h0);
        wb_cycle(1'b0, 4'h4, 32'h0); check(rd, 32'h1);
        wb_cycle(1'b0, 4'h8, 32'h0); check(rd, 32'h0);
        expect_clk(12, 6);
        $display("Test reset done");
    endtask : t_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    initial begin
        reset_n = 1'b0;
        wb_req = '0;
        repeat (3) @(posedge clock);
        reset_n <= 1'b1;
        t_regs();
        t_sources();
        t_divide();
        t_pll();
        t_reset();
        end_sim();
    end
endmodule : system_clock_source_select_bench
